// *** capture_timer.sv ***
// Two timer units, two 8-bit capture channels each, with noise filters.
// Assumes event pins synchronous-safe after two flops, one clock domain.
//
// Summary of operation
// - Selected edge copies counter to data register
// - Function field selects capture edge
// - Free-run and clear variants via function field
// - Clear mode: store, flag, zero, keep counting
// - Free-run mode: store, flag, keep counting
// - Captures never touch buffer full flag
// - Counter overflow sets overflow flag
// - Timer output toggles on each overflow
// - Output starting level from initial value bit
// - Second unit behaves identically
// - Optional noise filter on event inputs
// - Filter removes high, low or both pulses
// - Pulses up to three cycles are removed
// - Filtered input delayed three cycles more than unfiltered
// - Both-edge start while high skips first fall
// - Standby halts counting; clear-mode captures still zero the counter
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module capture_timer #(
    parameter int UNITS = 2
) (
    input  wire logic                             clk,
    input  wire logic                             reset_n,
    input  wire logic [capture_pkg::ADDR_W-1:0]   addr,
    input  wire logic [capture_pkg::DATA_W-1:0]   wr_data,
    input  wire logic                             wr_en,
    input  wire logic                             rd_en,
    output logic      [capture_pkg::DATA_W-1:0]   rd_data,
    input  wire logic                             event_input_pin0,
    input  wire logic                             event_input_pin1,
    input  wire logic                             standby,
    output logic      [2*UNITS-1:0]               timer_out,
    output logic                                  irq
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic capture_pkg::cap_mode_s decode_fn(
        input logic [3:0] fn
    );
        capture_pkg::cap_mode_s m;
        m = '0;
        case (fn)
            capture_pkg::FN_RISE_FREE:  m = 4'b1100;
            capture_pkg::FN_FALL_FREE:  m = 4'b1010;
            capture_pkg::FN_BOTH_FREE:  m = 4'b1110;
            capture_pkg::FN_RISE_CLEAR: m = 4'b1101;
            capture_pkg::FN_FALL_CLEAR: m = 4'b1011;
            capture_pkg::FN_BOTH_CLEAR: m = 4'b1111;
            default:                    m = 4'b0000;
        endcase
        return m;
    endfunction : decode_fn

    // Divide by two to the power of the select; top code is slowest
    function automatic logic count_tick(
        input logic [7:0] presc,
        input logic [2:0] sel
    );
        logic [7:0] mask;
        mask = 8'((9'h001 << sel) - 9'h001);
        return (presc & mask) == capture_pkg::COUNT_ZERO;
    endfunction : count_tick

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        capture_pkg::chan_s [2*UNITS-1:0] ch;
        capture_pkg::unit_s [UNITS-1:0]   un;
        logic [2*2*UNITS-1:0]             status;
        logic [2*2*UNITS-1:0]             mask;
        logic [7:0]                       presc;
        logic [capture_pkg::DATA_W-1:0]   rd_data;
        logic                             irq;
    } state_s;

    state_s state_q;
    state_s state_d;

    always_comb
    begin
        logic [UNITS-1:0]             pins;
        logic [2*2*UNITS-1:0]         set_bits;
        logic [2*2*UNITS-1:0]         clr_bits;
        logic [2*2*UNITS-1:0]         en_bits;
        logic [capture_pkg::ADDR_W-1:0] base;
        logic [capture_pkg::DATA_W-1:0] rdv;
        capture_pkg::cap_mode_s       m;
        logic                         hi_f;
        logic                         lo_f;
        logic [3:0]                   h;
        logic                         rise;
        logic                         fall;
        logic                         cap;
        logic                         cnt_en;
        logic                         ovf;
        logic                         start;
        int                           u;
        int                           c;
        pins     = '0;
        set_bits = '0;
        clr_bits = '0;
        en_bits  = '0;
        base     = '0;
        rdv      = capture_pkg::REG_RESET;
        m        = '0;
        hi_f     = 1'b0;
        lo_f     = 1'b0;
        h        = '0;
        rise     = 1'b0;
        fall     = 1'b0;
        cap      = 1'b0;
        cnt_en   = 1'b0;
        ovf      = 1'b0;
        start    = 1'b0;
        u        = 0;
        pins[0]  = event_input_pin0;
        if (UNITS > 1)
        begin
            pins[UNITS-1] = event_input_pin1;
        end
        state_d       = state_q;
        state_d.presc = 8'(state_q.presc + 8'h01);

        // ********************************************************
        // Register writes
        // ********************************************************
        for (int i = 0; i < UNITS; i++)
        begin
            base = 5'(capture_pkg::UNIT_STRIDE * i);
            if (wr_en)
            begin
                for (int k = 0; k < 2; k++)
                begin
                    c = 2 * i + k;
                    if (addr == base + 5'(capture_pkg::OFS_CTRL0_CH0) + 5'(k))
                    begin
                        state_d.ch[c].ctrl0 = wr_data;
                    end
                    // Flag bits are mirrors; cleared via status
                    if (addr == base + 5'(capture_pkg::OFS_CTRL1_CH0) + 5'(k))
                    begin
                        state_d.ch[c].ctrl1 = wr_data;
                    end
                    if (addr == base + 5'(capture_pkg::OFS_DATA_CH0) + 5'(k))
                    begin
                        state_d.ch[c].data = wr_data;
                    end
                end
                if (addr == base + 5'(capture_pkg::OFS_MODE_CTRL))
                begin
                    state_d.un[i].input_pin_select  = wr_data[capture_pkg::MC_TIS];
                    state_d.un[i].width_16bit_select  = wr_data[capture_pkg::MC_MOD];
                    state_d.un[i].filt = wr_data[capture_pkg::MC_FILT_HI:0];
                end
            end
        end
        if (wr_en && addr == capture_pkg::ADDR_IRQ_MASK)
        begin
            state_d.mask = wr_data[2*2*UNITS-1:0];
        end
        if (wr_en && addr == capture_pkg::ADDR_IRQ_STATUS)
        begin
            clr_bits = wr_data[2*2*UNITS-1:0];
        end

        // ********************************************************
        // Per-channel capture engine
        // ********************************************************
        for (int i = 0; i < UNITS; i++)
        begin
            u = i;
            // First stage only feeds the second
            state_d.un[i].sync1 = pins[i];
            state_d.un[i].sync2 = state_q.un[i].sync1;
            for (int k = 0; k < 2; k++)
            begin
                c    = 2 * i + k;
                m    = decode_fn(state_q.ch[c].ctrl0[capture_pkg::CR0_FN_HI:
                                                     capture_pkg::CR0_FN_LO]);
                hi_f = state_q.un[u].filt[2*k+1] & m.valid;
                lo_f = state_q.un[u].filt[2*k] & m.valid;

                // Four-sample window: a level must hold four cycles
                h = {state_q.ch[c].hist[2:0], state_q.un[u].sync2};
                state_d.ch[c].hist = h;
                if (!hi_f && !lo_f)
                begin
                    state_d.ch[c].filt_lvl = state_q.un[u].sync2;
                end
                else if (state_q.ch[c].filt_lvl)
                begin
                    if (lo_f ? (h == 4'h0) : !h[capture_pkg::FILTER_CYCLES-1])
                    begin
                        state_d.ch[c].filt_lvl = 1'b0;
                    end
                end
                else
                begin
                    if (hi_f ? (h == 4'hF) : h[capture_pkg::FILTER_CYCLES-1])
                    begin
                        state_d.ch[c].filt_lvl = 1'b1;
                    end
                end

                state_d.ch[c].lvl_prev = state_q.ch[c].filt_lvl;
                rise = state_q.ch[c].filt_lvl & ~state_q.ch[c].lvl_prev;
                fall = ~state_q.ch[c].filt_lvl & state_q.ch[c].lvl_prev;

                state_d.ch[c].run_prev = state_q.ch[c].ctrl1[capture_pkg::CR1_RUN];
                start = state_q.ch[c].ctrl1[capture_pkg::CR1_RUN] &
                        ~state_q.ch[c].run_prev;
                cnt_en = state_q.ch[c].ctrl1[capture_pkg::CR1_RUN] &
                         ~state_q.ch[c].ctrl1[capture_pkg::CR1_PAUSE] &
                         ~standby &
                         count_tick(state_q.presc,
                             state_q.ch[c].ctrl0[capture_pkg::CR0_CLK_HI:
                                                 capture_pkg::CR0_CLK_LO]);

                if (rise)
                begin
                    state_d.ch[c].armed = 1'b1;
                end
                cap = state_q.ch[c].ctrl1[capture_pkg::CR1_RUN] & !start &
                      ((m.rise & rise) |
                       (m.fall & fall &
                        (!(m.rise) | state_q.ch[c].armed)));
                ovf = cnt_en & (state_q.ch[c].count == capture_pkg::COUNT_MAX);

                if (start)
                begin
                    state_d.ch[c].count   = capture_pkg::COUNT_ZERO;
                    state_d.ch[c].out_lvl =
                        state_q.ch[c].ctrl1[capture_pkg::CR1_SO];
                    state_d.ch[c].armed   = ~state_q.ch[c].filt_lvl;
                end
                else if (cap && m.clear)
                begin
                    state_d.ch[c].count = capture_pkg::COUNT_ZERO;
                end
                else if (cnt_en)
                begin
                    state_d.ch[c].count = 8'(state_q.ch[c].count + 8'h01);
                end
                if (cap)
                begin
                    state_d.ch[c].data = state_q.ch[c].count;
                end
                if (ovf && !(cap && m.clear) && !start)
                begin
                    state_d.ch[c].out_lvl = ~state_q.ch[c].out_lvl;
                end
                set_bits[2*c]   = cap;
                set_bits[2*c+1] = ovf && !(cap && m.clear) && !start;
                en_bits[2*c]    = state_q.ch[c].ctrl1[capture_pkg::CR1_IE];
                en_bits[2*c+1]  = state_q.ch[c].ctrl0[capture_pkg::CR0_IFE];
            end
        end

        // Set beats a simultaneous write-one clear
        state_d.status = (state_q.status & ~clr_bits) | set_bits;
        state_d.irq    = |(state_q.status & state_q.mask & en_bits);

        // ********************************************************
        // Register reads
        // ********************************************************
        if (addr == capture_pkg::ADDR_IRQ_STATUS)
        begin
            rdv = 8'(state_q.status);
        end
        if (addr == capture_pkg::ADDR_IRQ_MASK)
        begin
            rdv = 8'(state_q.mask);
        end
        for (int i = 0; i < UNITS; i++)
        begin
            base = 5'(capture_pkg::UNIT_STRIDE * i);
            for (int k = 0; k < 2; k++)
            begin
                c = 2 * i + k;
                if (addr == base + 5'(capture_pkg::OFS_CTRL0_CH0) + 5'(k))
                begin
                    rdv = state_q.ch[c].ctrl0;
                end
                if (addr == base + 5'(capture_pkg::OFS_CTRL1_CH0) + 5'(k))
                begin
                    rdv = state_q.ch[c].ctrl1;
                    rdv[capture_pkg::CR1_IR] = state_q.status[2*c];
                    rdv[capture_pkg::CR1_IF] = state_q.status[2*c+1];
                end
                if (addr == base + 5'(capture_pkg::OFS_DATA_CH0) + 5'(k))
                begin
                    rdv = state_q.ch[c].data;
                end
            end
            if (addr == base + 5'(capture_pkg::OFS_MODE_CTRL))
            begin
                rdv = {state_q.ch[2*i+1].out_lvl, state_q.ch[2*i].out_lvl,
                       state_q.un[i].input_pin_select, state_q.un[i].width_16bit_select,
                       state_q.un[i].filt};
            end
        end
        // Unmapped addresses and idle cycles read as zero
        state_d.rd_data = rd_en ? rdv : capture_pkg::REG_RESET;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    always_comb
    begin
        for (int j = 0; j < 2 * UNITS; j++)
        begin
            timer_out[j] = state_q.ch[j].out_lvl;
        end
    end

    assign rd_data = state_q.rd_data;
    assign irq     = state_q.irq;

endmodule : capture_timer

// *** capture_pkg.sv ***
// Constants, register map and carriers for the dual-unit capture timer.
// Assumes an 8-bit register port with one-cycle read latency.
package capture_pkg;

    // ************************************************************
    // Register map (index per unit, unit stride added)
    // ************************************************************
    localparam int         ADDR_W          = 5;
    localparam int         DATA_W          = 8;
    localparam logic [4:0] UNIT_STRIDE     = 5'h08;
    localparam logic [2:0] OFS_CTRL0_CH0   = 3'h0;
    localparam logic [2:0] OFS_CTRL0_CH1   = 3'h1;
    localparam logic [2:0] OFS_CTRL1_CH0   = 3'h2;
    localparam logic [2:0] OFS_CTRL1_CH1   = 3'h3;
    localparam logic [2:0] OFS_MODE_CTRL   = 3'h4;
    localparam logic [2:0] OFS_DATA_CH0    = 3'h5;
    localparam logic [2:0] OFS_DATA_CH1    = 3'h6;
    localparam logic [4:0] ADDR_IRQ_STATUS = 5'h10;
    localparam logic [4:0] ADDR_IRQ_MASK   = 5'h11;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CR0_IFE    = 7;
    localparam int CR0_CLK_HI = 6;
    localparam int CR0_CLK_LO = 4;
    localparam int CR0_FN_HI  = 3;
    localparam int CR0_FN_LO  = 0;
    localparam int CR1_RUN    = 7;
    localparam int CR1_PAUSE  = 6;
    localparam int CR1_IE     = 5;
    localparam int CR1_IR     = 4;
    localparam int CR1_BF     = 3;
    localparam int CR1_IF     = 2;
    localparam int CR1_SO     = 1;
    localparam int CR1_OE     = 0;
    localparam int MC_TO1     = 7;
    localparam int MC_TO0     = 6;
    localparam int MC_TIS     = 5;
    localparam int MC_MOD     = 4;
    localparam int MC_FILT_HI = 3;

    // ************************************************************
    // Capture function codes and timing
    // ************************************************************
    localparam logic [3:0] FN_RISE_FREE  = 4'hA;
    localparam logic [3:0] FN_FALL_FREE  = 4'hB;
    localparam logic [3:0] FN_BOTH_FREE  = 4'hC;
    localparam logic [3:0] FN_RISE_CLEAR = 4'hD;
    localparam logic [3:0] FN_FALL_CLEAR = 4'hE;
    localparam logic [3:0] FN_BOTH_CLEAR = 4'hF;
    localparam int         FILTER_CYCLES = 4;
    localparam logic [7:0] COUNT_ZERO    = 8'h00;
    localparam logic [7:0] COUNT_MAX     = 8'hFF;
    localparam logic [7:0] REG_RESET     = 8'h00;

    typedef struct packed {
        logic       valid;
        logic       rise;
        logic       fall;
        logic       clear;
    } cap_mode_s;

    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] count;
        logic [7:0] data;
        logic       out_lvl;
        logic       run_prev;
        logic       armed;
        logic [3:0] hist;
        logic       filt_lvl;
        logic       lvl_prev;
    } chan_s;

    typedef struct packed {
        logic       input_pin_select;
        logic       width_16bit_select;
        logic [3:0] filt;
        logic       sync1;
        logic       sync2;
    } unit_s;

endpackage : capture_pkg

// *** capture_timer_checker.sv ***
// Checker for the capture timer register port, interrupt and outputs.
// Assumes it is bound into capture_timer and sees only its ports.
`timescale 1ns/1ps
module capture_timer_checker #(
    parameter int UNITS = 2
) (
    input wire logic               clk,
    input wire logic               reset_n,
    input wire logic [4:0]         addr,
    input wire logic [7:0]         wr_data,
    input wire logic               wr_en,
    input wire logic               rd_en,
    input wire logic [7:0]         rd_data,
    input wire logic               standby,
    input wire logic [2*UNITS-1:0] timer_out,
    input wire logic               irq
);
    // ********************************
    // Shadow of written registers
    // ********************************
    logic [7:0] shad_q [0:31];
    logic [7:0] exp_q;
    logic [4:0] ra_q;
    logic       rd_q;
    logic [7:0] mask;
    logic       any_en;
    logic       run_any;

    assign mask    = shad_q[17];
    assign any_en  = shad_q[0][7] | shad_q[1][7] | shad_q[8][7] | shad_q[9][7]
                   | shad_q[2][5] | shad_q[3][5] | shad_q[10][5]
                   | shad_q[11][5];
    assign run_any = shad_q[2][7] | shad_q[3][7] | shad_q[10][7]
                   | shad_q[11][7];

    always_ff @(posedge clk)
    begin
        rd_q  <= reset_n && rd_en;
        exp_q <= shad_q[addr];
        ra_q  <= addr;
        for (int i = 0; i < 32; i++)
        begin
            if (!reset_n)
                shad_q[i] <= 8'h00;
            else if (wr_en && addr == 5'(i))
                shad_q[i] <= wr_data;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    ctrl_zero_rb_a: assert property
        (rd_q && !ra_q[4] && ra_q[2:1] == 2'b00 |-> rd_data == exp_q)
        else $error("function control readback differs");
    ctrl_one_rb_a: assert property
        (rd_q && !ra_q[4] && ra_q[2:1] == 2'b01
         |-> (rd_data & 8'hEB) == (exp_q & 8'hEB))
        else $error("run control readback differs");
    mode_rb_a: assert property
        (rd_q && !ra_q[4] && ra_q[2:0] == 3'h4
         |-> rd_data[5:0] == exp_q[5:0])
        else $error("filter select readback differs");
    mask_rb_a: assert property
        (rd_q && ra_q == 5'h11 |-> rd_data == exp_q)
        else $error("mask readback differs");
    irq_masked_a: assert property
        (irq |-> mask != 8'h00)
        else $error("interrupt with all sources masked");
    irq_enable_a: assert property
        (irq |-> any_en)
        else $error("interrupt with no source enabled");
    standby_hold_a: assert property
        ((standby && !wr_en) [*3] |=> $stable(timer_out))
        else $error("output moved in standby");
    out_toggle_a: assert property
        ($changed(timer_out)
         |-> run_any || $past(run_any) || $past(wr_en) || $past(wr_en, 2))
        else $error("output moved with no channel running");
    run_start_a: assert property
        (wr_en && addr == 5'h02 && wr_data[7] && !shad_q[2][7]
         |-> ##[1:3] timer_out[0] == shad_q[2][1])
        else $error("start level not loaded");
endmodule : capture_timer_checker

bind capture_timer capture_timer_checker #(.UNITS(UNITS)) i_chk (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .standby(standby),
    .timer_out(timer_out), .irq(irq)
);

// *** event_source.sv ***
// Pulse source model driving both event input pins.
// Assumes one bench process calls its tasks at a time.
`timescale 1ns/1ps
module event_source (
    input  wire logic clk,
    output logic      event_input_pin0,
    output logic      event_input_pin1
);
    initial
    begin
        event_input_pin0 = 1'b0;
        event_input_pin1 = 1'b0;
    end

    // Changes just after an edge, like a clocked source
    task automatic level(input int p, input logic v);
        @(posedge clk);
        if (p == 0)
            event_input_pin0 <= v;
        else
            event_input_pin1 <= v;
    endtask : level

    task automatic pulse(input int p, input logic v, input int w);
        level(p, v);
        repeat (w - 1) @(posedge clk);
        level(p, !v);
    endtask : pulse
endmodule : event_source

// *** test_input_capture_noise_filter.sv ***
// Self-checking bench for the dual-unit capture timer with noise filter.
// Assumes capture_pkg, the pulse source and the checker are compiled.
`timescale 1ns/1ps
module test_input_capture_noise_filter;
    // ********************************
    // Signals
    // ********************************
    localparam logic [4:0] ST = capture_pkg::ADDR_IRQ_STATUS;
    localparam logic [2:0] D0 = capture_pkg::OFS_DATA_CH0;
    logic       clk;
    logic       reset_n;
    logic [4:0] addr;
    logic [7:0] wr_data;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] rd_data;
    logic       pin0;
    logic       pin1;
    logic       standby;
    logic [3:0] timer_out;
    logic       irq;
    int         fails;
    int         n_compared;
    int         seed = 32'hde0c;
    logic [7:0] v;
    logic [7:0] a;
    logic [7:0] b;

    capture_timer #(
        .UNITS(2)
    ) i_dut (
        .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .event_input_pin0(pin0), .event_input_pin1(pin1),
        .standby(standby), .timer_out(timer_out), .irq(irq)
    );
    event_source i_src (
        .clk(clk), .event_input_pin0(pin0), .event_input_pin1(pin1)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ********************************
    // Bus tasks and expectations
    // ********************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [4:0] ad, input logic [7:0] dt);
        @(posedge clk);
        addr    <= ad;
        wr_data <= dt;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] ad, output logic [7:0] dt);
        @(posedge clk);
        addr  <= ad;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 dt = rd_data;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    function automatic logic [4:0] ra(input int c, input logic [2:0] ofs);
        return 5'(c / 2) * capture_pkg::UNIT_STRIDE + 5'(ofs) + 5'(c % 2);
    endfunction : ra

    function automatic logic edge_hit(input logic [3:0] fn, input int e);
        int k;
        k = (fn - capture_pkg::FN_RISE_FREE) % 3;
        return k == 2 || k == 1 - e;
    endfunction : edge_hit

    // Stop first, so every start is a fresh 0 to 1 of run
    task automatic arm(input int c, input logic [7:0] c0,
                       input logic [7:0] c1);
        wr(ra(c, capture_pkg::OFS_CTRL1_CH0), 8'h00);
        wr(ra(c, capture_pkg::OFS_CTRL0_CH0), c0);
        wr(ra(c, capture_pkg::OFS_CTRL1_CH0), c1);
    endtask : arm

    task automatic gap(input int s, output logic [7:0] df);
        logic [7:0] x;
        i_src.pulse(0, 1'b1, 4);
        idle(6);
        rd(ra(0, D0), x);
        @(posedge clk);
        standby <= (s > 0);
        idle(s);
        standby <= 1'b0;
        i_src.pulse(0, 1'b1, 4);
        idle(8);
        rd(ra(0, D0), df);
        df = df - x;
    endtask : gap

    task automatic stop_test;
        $display("compared %0d, mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    initial
    begin
        idle(20000);
        fails++;
        stop_test();
    end

    // ********************************
    // Main sequence
    // ********************************
    initial
    begin
        int d;
        reset_n = 1'b0;
        addr    = 5'h00;
        wr_data = 8'h00;
        wr_en   = 1'b0;
        rd_en   = 1'b0;
        standby = 1'b0;
        idle(8);
        reset_n <= 1'b1;
        for (int i = 0; i < 32; i++)
        begin
            rd(5'(i), v);
            check(v, capture_pkg::REG_RESET);
        end
        for (int i = 0; i < 12; i++)
        begin
            a = 8'({$random(seed)} % 5 + ({$random(seed)} % 2) * 8);
            b = 8'($random(seed));
            wr(a[4:0], b);
            rd(a[4:0], v);
            d = (a[2:0] == 3'h4) ? 8'h3F : (a[2:1] == 2'b01) ? 8'hEB : 8'hFF;
            check(v & 8'(d), b & 8'(d));
        end
        for (int i = 0; i < 13; i++)
            wr(5'(i), 8'h00);
        // Clear mode: second capture holds the rise spacing less one
        arm(0, {4'h0, capture_pkg::FN_RISE_CLEAR}, 8'h80);
        d = 20 + {$random(seed)} % 40;
        i_src.pulse(0, 1'b1, 5);
        idle(d - 6);
        i_src.pulse(0, 1'b1, 5);
        idle(8);
        rd(ra(0, D0), v);
        check(v, 8'(d - 1));
        // Unfiltered and filtered channel on one pin
        wr(5'h04, 8'h0C);
        arm(0, {4'h0, capture_pkg::FN_RISE_FREE}, 8'h80);
        arm(1, {4'h0, capture_pkg::FN_RISE_FREE}, 8'h80);
        i_src.pulse(0, 1'b1, 6);
        idle(10);
        rd(ra(0, D0), a);
        rd(ra(1, D0), b);
        // Second channel starts six cycles later; window adds three
        check(b, 8'(a + capture_pkg::FILTER_CYCLES - 7));
        i_src.pulse(0, 1'b1, 6);
        idle(10);
        rd(ra(0, D0), v);
        check(v, 8'(a + 21));
        for (int f = 1; f < 4; f++)
            for (int p = 0; p < 2; p++)
                for (int w = 3; w < 5; w++)
                begin
                    wr(5'h04, 8'(f << 2));
                    i_src.level(0, 1'(p == 0));
                    idle(12);
                    wr(ST, 8'hFF);
                    i_src.pulse(0, 1'(p), w);
                    idle(12);
                    rd(ST, v);
                    check(v[0], 8'h01);
                    check(v[2], 8'(w == 4 || (p ? f[1] : f[0]) == 0));
                end
        // Every edge code on the second unit
        for (int k = 0; k < 6; k++)
        begin
            arm(2, {4'h0, capture_pkg::FN_RISE_FREE + 4'(k)}, 8'h80);
            for (int e = 1; e >= 0; e--)
            begin
                wr(ST, 8'h10);
                i_src.level(1, 1'(e));
                idle(10);
                rd(ST, v);
                check(v[4], 8'(edge_hit(4'hA + 4'(k), e)));
            end
        end
        // Both edges armed while high: first fall skipped
        i_src.level(1, 1'b1);
        arm(2, {4'h0, capture_pkg::FN_BOTH_CLEAR}, 8'h88);
        idle(6);
        wr(ST, 8'h10);
        for (int e = 0; e < 2; e++)
        begin
            i_src.level(1, 1'(e));
            idle(10);
            rd(ST, v);
            check(v[4], 8'(e));
        end
        rd(ra(2, capture_pkg::OFS_CTRL1_CH0), v);
        check(v[4:3], 8'h03);
        // Overflow, output toggle and interrupt
        arm(0, {1'b1, 3'h0, capture_pkg::FN_RISE_FREE}, 8'h82);
        idle(3);
        check(timer_out[0], 8'h01);
        wr(ST, 8'h02);
        idle(256);
        check(timer_out[0], 8'h00);
        rd(ST, v);
        check(v[1], 8'h01);
        check(irq, 8'h00);
        wr(capture_pkg::ADDR_IRQ_MASK, 8'h02);
        idle(2);
        check(irq, 8'h01);
        wr(ST, 8'h02);
        idle(2);
        check(irq, 8'h00);
        // Standby freezes the count between two captures
        gap(0, a);
        gap(20 + {$random(seed)} % 40, b);
        check(b, a);
        stop_test();
    end
endmodule : test_input_capture_noise_filter
